// File: core/acc_pkg.sv
/*
 Constants for the converter control block: register offsets, field positions,
 reset values and timing counts. Assumes a 25 MHz system clock.
*/
package acc_pkg;
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_PINCFG = 12'h004;
   localparam logic [11:0] OFF_CAJCFG = 12'h008;
   localparam logic [11:0] OFF_RESH = 12'h00C;
   localparam logic [11:0] OFF_RESL = 12'h010;
   localparam int CTRL_ON_BIT = 0;
   localparam int CTRL_GO_BIT = 1;
   localparam int CTRL_CHS_LO = 2;
   localparam int CAJ_CLK_LO = 0;
   localparam int CAJ_ACQ_LO = 3;
   localparam int CAJ_JUST_BIT = 7;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] PINCFG_RST = 8'h00;
   localparam logic [7:0] CAJCFG_RST = 8'h00;
   localparam int RES_BITS = 10;
   localparam int SYS_CLK_MHZ = 25;
   localparam int TAD_NS = 1600;
   localparam int TAD_CYC = (TAD_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int CONV_TAD = 11;
   typedef enum logic [1:0] {
      ACC_IDLE = 2'b00,
      ACC_ACQ = 2'b01,
      ACC_CONV = 2'b10
   } acc_state_t;
endpackage

// File: core/acc_sar.sv
/*
 Successive approximation engine: one bit per step, MSB first.
 Assumes a comparator input that settles within one step.
*/
`timescale 1ns/1ps
module acc_sar #(
   parameter int BITS = 10
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic start,
   input wire logic step,
   input wire logic cmp_hi,
   output logic [BITS-1:0] trial,
   output logic done
);
   import acc_pkg::*;
   typedef struct packed {
      logic [BITS-1:0] code;
      logic [BITS-1:0] bitm;
      logic done;
   } acc_sar_t;
   acc_sar_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (start) begin
         s_d.bitm = {1'b1, {(BITS-1){1'b0}}};
         s_d.code = {1'b1, {(BITS-1){1'b0}}};
      end else if (step && (s_q.bitm != '0)) begin
         // Keep or drop the trial bit, then try the next lower one
         if (!cmp_hi) begin
            s_d.code = s_q.code & ~s_q.bitm;
         end
         s_d.bitm = s_q.bitm >> 1;
         s_d.code = s_d.code | (s_q.bitm >> 1);
         s_d.done = (s_q.bitm[0] == 1'b1);
      end
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign trial = s_q.code;
   assign done = s_q.done;
endmodule

// File: core/acc_top.sv
/*
 Converter control block: AHB-Lite register slave, acquisition timer,
 conversion sequencing and result registers.
 Assumes an analog multiplexer and comparator core outside; the comparator
 answer arrives asynchronously and is synchronised here.
*/
//
// Contract
// - Convert selected input to unsigned 10-bit code
// - Acquire for programmed time, then convert
// - Channel write and start in one access
// - Bits 5..2 select input n
// - Small variant 12 inputs, large 16
// - Start flag reads busy, clears when done
// - Enable bit powers converter on
// - Top two control bits read zero
// - Config selects clock, acquisition, justification
// - Result readable as high and low registers
// - Pin config selects analog or digital pins
`timescale 1ns/1ps
module acc_top #(
   parameter int NUM_INPUTS = 16
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic cmp_hi,
   output logic [3:0] mux_sel,
   output logic sample_en,
   output logic [acc_pkg::RES_BITS-1:0] dac_code,
   output logic conv_power,
   output logic [7:0] pin_analog
);
   import acc_pkg::*;
   typedef struct packed {
      logic wr_pend;
      logic [11:0] wr_addr;
      logic [7:0] ctrl;
      logic [7:0] pincfg;
      logic [7:0] cajcfg;
      logic [RES_BITS-1:0] result;
      acc_state_t st;
      logic [12:0] tad_cnt;
      logic [5:0] acq_left;
      logic sar_start;
      logic [31:0] rdata;
      logic [1:0] cmp_sync;
      logic [3:0] mux;
      logic sample;
   } acc_top_t;
   acc_top_t r_q, r_d;
   logic tad_tick;
   logic [RES_BITS-1:0] trial;
   logic sar_done;
   logic [12:0] tad_div;
   logic [5:0] acq_tads;
   logic [7:0] wbyte;
   logic [15:0] just_res;

   acc_sar #(
      .BITS(RES_BITS)
   ) u_sar (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .start(r_q.sar_start),
      .step(tad_tick && (r_q.st == ACC_CONV)),
      .cmp_hi(r_q.cmp_sync[1]),
      .trial(trial),
      .done(sar_done)
   );

   // Conversion clock divider and acquisition length
   always_comb begin
      tad_div = 13'(TAD_CYC) << r_q.cajcfg[CAJ_CLK_LO +: 3];
      case (r_q.cajcfg[CAJ_ACQ_LO +: 3])
         3'h0: acq_tads = 6'h01;
         3'h1: acq_tads = 6'h02;
         3'h2: acq_tads = 6'h04;
         3'h3: acq_tads = 6'h06;
         3'h4: acq_tads = 6'h08;
         3'h5: acq_tads = 6'h0C;
         3'h6: acq_tads = 6'h10;
         default: acq_tads = 6'h14;
      endcase
      // Left or right justification of the result pair
      if (r_q.cajcfg[CAJ_JUST_BIT]) begin
         just_res = {6'h00, r_q.result};
      end else begin
         just_res = {r_q.result, 6'h00};
      end
   end
   assign tad_tick = (r_q.tad_cnt >= (tad_div - 13'h0001));
   assign wbyte = hwdata[7:0];

   always_comb begin
      r_d = r_q;
      r_d.sar_start = 1'b0;
      r_d.cmp_sync = {r_q.cmp_sync[0], cmp_hi};
      if (r_q.st == ACC_IDLE || tad_tick) begin
         r_d.tad_cnt = 13'h0000;
      end else begin
         r_d.tad_cnt = r_q.tad_cnt + 13'h0001;
      end
      // Sequencer: acquisition first, then conversion
      case (r_q.st)
         ACC_IDLE: begin
            r_d.sample = 1'b0;
         end
         ACC_ACQ: begin
            r_d.sample = 1'b1;
            if (tad_tick) begin
               if (r_q.acq_left == 6'h01) begin
                  r_d.st = ACC_CONV;
                  r_d.sample = 1'b0;
                  r_d.sar_start = 1'b1;
               end else begin
                  r_d.acq_left = r_q.acq_left - 6'h01;
               end
            end
         end
         ACC_CONV: begin
            r_d.sample = 1'b0;
            if (sar_done) begin
               // Result and busy flag change together
               r_d.result = trial;
               r_d.ctrl[CTRL_GO_BIT] = 1'b0;
               r_d.st = ACC_IDLE;
            end
         end
         default: r_d.st = ACC_IDLE;
      endcase
      // Register write data phase
      r_d.wr_pend = 1'b0;
      if (r_q.wr_pend) begin
         case (r_q.wr_addr)
            OFF_CTRL: begin
               // Top bits dropped; channel and start taken together
               r_d.ctrl = {2'b00, wbyte[5:0]};
               // Busy keeps its state; a completion in this cycle still clears it
               if (r_q.st != ACC_IDLE) begin
                  r_d.ctrl[CTRL_GO_BIT] = (r_d.st != ACC_IDLE);
               end
               if (wbyte[CTRL_GO_BIT] && wbyte[CTRL_ON_BIT] && r_q.st == ACC_IDLE) begin
                  r_d.st = ACC_ACQ;
                  r_d.acq_left = acq_tads;
                  r_d.tad_cnt = 13'h0000;
               end else if (r_q.st == ACC_IDLE) begin
                  r_d.ctrl[CTRL_GO_BIT] = 1'b0;
               end
               // Turning off aborts any conversion
               if (!wbyte[CTRL_ON_BIT]) begin
                  r_d.ctrl[CTRL_GO_BIT] = 1'b0;
                  r_d.st = ACC_IDLE;
               end
            end
            OFF_PINCFG: r_d.pincfg = wbyte;
            OFF_CAJCFG: r_d.cajcfg = wbyte;
            default: ;
         endcase
      end
      // Sample strobe spans the whole acquisition state
      r_d.sample = (r_d.st == ACC_ACQ);
      // Multiplexer follows the selector; codes past the variant read as input 0
      if (r_d.ctrl[CTRL_CHS_LO +: 4] < 4'(NUM_INPUTS) || NUM_INPUTS >= 16) begin
         r_d.mux = r_d.ctrl[CTRL_CHS_LO +: 4];
      end else begin
         r_d.mux = 4'h0;
      end
      // Address phase
      if (hsel && hready && htrans[1]) begin
         r_d.wr_pend = hwrite;
         r_d.wr_addr = haddr[11:0];
         case (haddr[11:0])
            OFF_CTRL: r_d.rdata = {24'h0000_00, r_q.ctrl};
            OFF_PINCFG: r_d.rdata = {24'h0000_00, r_q.pincfg};
            OFF_CAJCFG: r_d.rdata = {24'h0000_00, r_q.cajcfg};
            OFF_RESH: r_d.rdata = {24'h0000_00, just_res[15:8]};
            OFF_RESL: r_d.rdata = {24'h0000_00, just_res[7:0]};
            default: r_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         r_q <= '0;
         r_q.ctrl <= CTRL_RST;
         r_q.pincfg <= PINCFG_RST;
         r_q.cajcfg <= CAJCFG_RST;
         r_q.st <= ACC_IDLE;
      end else begin
         r_q <= r_d;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hrdata <= 32'h0000_0000;
         mux_sel <= 4'h0;
         sample_en <= 1'b0;
         dac_code <= '0;
         conv_power <= 1'b0;
         pin_analog <= 8'h00;
      end else begin
         hrdata <= r_d.rdata;
         mux_sel <= r_d.mux;
         sample_en <= r_d.sample;
         dac_code <= trial;
         conv_power <= r_d.ctrl[CTRL_ON_BIT];
         pin_analog <= r_d.pincfg;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   sequence go_written_s;
      r_q.wr_pend && r_q.wr_addr == OFF_CTRL && hwdata[1] && hwdata[0] && r_q.st == ACC_IDLE;
   endsequence
   start_acq_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      go_written_s |=> r_q.st == ACC_ACQ && r_q.ctrl[1])
      else $error("start did not enter acquisition");
   acq_first_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      r_q.st == ACC_IDLE ##1 r_q.st == ACC_CONV |-> 1'b0)
      else $error("conversion began without acquisition");
   busy_flag_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      r_q.st != ACC_IDLE |-> r_q.ctrl[1])
      else $error("busy flag low during conversion");
   done_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      r_q.st == ACC_CONV && sar_done |=> !r_q.ctrl[1] && r_q.result == $past(trial))
      else $error("result and flag not updated together");
   top_zero_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      r_q.ctrl[7:6] == 2'b00)
      else $error("unimplemented bits set");
   chan_sel_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      NUM_INPUTS >= 16 |-> ##1 mux_sel == $past(r_d.ctrl[5:2]))
      else $error("multiplexer select mismatch");
   off_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !r_q.ctrl[0] |-> r_q.st == ACC_IDLE && !conv_power)
      else $error("converter active while off");
   cfg_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      r_q.wr_pend && r_q.wr_addr == OFF_CAJCFG |=> r_q.cajcfg == $past(hwdata[7:0]))
      else $error("config write lost");
   pin_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      r_q.wr_pend && r_q.wr_addr == OFF_PINCFG |=> ##1 pin_analog == $past(hwdata[7:0], 2))
      else $error("pin config not applied");

   // Flag, strobe, counter, result hold, synchroniser and selector range checks
   idle_flag_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      r_q.st == ACC_IDLE |-> !r_q.ctrl[CTRL_GO_BIT])
      else $error("busy flag set while idle");
   sample_acq_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      sample_en == (r_q.st == ACC_ACQ))
      else $error("sample strobe outside acquisition");
   acq_count_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      r_q.st == ACC_ACQ |-> r_q.acq_left != 6'h00 && r_q.acq_left <= 6'h14)
      else $error("acquisition count out of range");
   result_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      !(r_q.st == ACC_CONV && sar_done) |=> $stable(r_q.result))
      else $error("result changed without completion");
   cmp_sync_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      $past(resetn, 2) |-> r_q.cmp_sync[1] == $past(cmp_hi, 2))
      else $error("comparator synchroniser skipped a stage");
   input_range_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      NUM_INPUTS >= 16 || mux_sel < 4'(NUM_INPUTS))
      else $error("selector past the inputs of this variant");

   // Start while off, acquisition end, control read and result low read
   // Start written with the enable bit clear
   sequence off_go_s;
      r_q.wr_pend && r_q.wr_addr == OFF_CTRL && hwdata[1] && !hwdata[0];
   endsequence
   off_start_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      off_go_s |=> r_q.st == ACC_IDLE && !r_q.ctrl[CTRL_GO_BIT] && !conv_power)
      else $error("start accepted while off");
   // Last acquisition tick with no control write pending
   sequence acq_end_s;
      r_q.st == ACC_ACQ && tad_tick && r_q.acq_left == 6'h01
         && !(r_q.wr_pend && r_q.wr_addr == OFF_CTRL);
   endsequence
   conv_begin_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      acq_end_s |=> r_q.st == ACC_CONV && r_q.sar_start && !sample_en)
      else $error("conversion did not follow acquisition");
   // Control register read taken in an address phase
   sequence ctrl_read_s;
      hsel && hready && htrans[1] && !hwrite && haddr[11:0] == OFF_CTRL;
   endsequence
   read_ctrl_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      ctrl_read_s |=> hrdata == {24'h0000_00, 2'b00, $past(r_q.ctrl[5:0])})
      else $error("control read shows unimplemented bits");
   low_pair_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      hsel && hready && htrans[1] && !hwrite && haddr[11:0] == OFF_RESL
         && r_q.cajcfg[CAJ_JUST_BIT] |=> hrdata == {24'h0000_00, $past(r_q.result[7:0])})
      else $error("right justified low byte wrong");
endmodule

// File: tb/acc_analog_model.sv
/*
 Far-side model: analog input multiplexer, sample-and-hold and comparator.
 Assumes the block drives mux_sel, sample_en and dac_code from sys_clk.
*/
`timescale 1ns/1ps
module acc_analog_model (
   input wire logic sys_clk,
   input wire logic [3:0] mux_sel,
   input wire logic sample_en,
   input wire logic conv_power,
   input wire logic [acc_pkg::RES_BITS-1:0] dac_code,
   output logic cmp_hi
);
   import acc_pkg::*;
   logic [RES_BITS-1:0] held;
   initial held = '0;
   // Input n carries n*61+7 in code units
   always @(posedge sys_clk) begin
      if (sample_en === 1'b1) begin
         held <= RES_BITS'(mux_sel * 61 + 7);
      end
   end
   // Comparing held >= dac_code with no offset makes the ideal code exact
   assign cmp_hi = conv_power & (held >= dac_code);
endmodule

// File: tb/acc_top_tb_top.sv
/*
 Testbench for the converter control block: AHB-Lite register tasks and
 conversion scenarios. Assumes zero-wait-state slave and the analog model.
*/
`timescale 1ns/1ps
module acc_top_tb_top;
   import acc_pkg::*;
   logic sys_clk = 0, resetn = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, cmp_hi, sample_en, conv_power;
   logic [3:0] mux_sel;
   logic [RES_BITS-1:0] dac_code, v;
   logic [7:0] pin_analog;
   int err_total = 0, n_checks = 0, cyc = 0, acq_n = 0;
   int chs[4] = '{0, 5, 12, 15};
   int acqc[4] = '{0, 1, 2, 7};
   int tads[8] = '{1, 2, 4, 6, 8, 12, 16, 20};
   always #20 sys_clk = ~sys_clk;
   acc_top uut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .cmp_hi(cmp_hi), .mux_sel(mux_sel), .sample_en(sample_en),
      .dac_code(dac_code), .conv_power(conv_power), .pin_analog(pin_analog));
   acc_analog_model far (.sys_clk(sys_clk), .mux_sel(mux_sel), .sample_en(sample_en),
      .conv_power(conv_power), .dac_code(dac_code), .cmp_hi(cmp_hi));
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (sample_en === 1'b1) acq_n++;
      if (cyc == 30000) begin
         err_total++;
         close_out();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One single word transfer; read data taken at the data phase edge
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      hsel <= 1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {20'h0_0000, a};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      r = hrdata;
      hsel <= 0;
   endtask
   initial begin
      repeat (2) @(posedge sys_clk);
      resetn <= 1;
      xfer(1, 12'h020, 32'hFFFF_FFFF);
      foreach (chs[i]) begin
         xfer(0, 12'h004 * i[11:0], 0);
         chk("reset value", 32'h0000_0000, r);
      end
      xfer(0, 12'h020, 0);
      chk("unmapped", 32'h0000_0000, r);
      chk("hresp", 32'h0000_0000, {31'h0, hresp});
      $display("test reset done");
      xfer(1, OFF_PINCFG, 32'h0000_00A5);
      xfer(0, OFF_PINCFG, 0);
      chk("pincfg", 32'h0000_00A5, r);
      chk("pin_analog", 32'h0000_00A5, {24'h0, pin_analog});
      xfer(1, OFF_CTRL, 32'h0000_00C1);
      xfer(0, OFF_CTRL, 0);
      chk("ctrl top bits", 32'h0000_0001, r);
      chk("conv_power", 1, {31'h0, conv_power});
      $display("test registers done");
      foreach (chs[i]) begin
         xfer(1, OFF_CAJCFG, {24'h0, i[0], 1'b0, acqc[i][2:0], i[2:0]});
         acq_n = 0;
         xfer(1, OFF_CTRL, {26'h0, chs[i][3:0], 2'b11});
         r = 32'h0000_0002;
         for (int k = 0; k < 4000 && r[1] !== 1'b0; k++) xfer(0, OFF_CTRL, 0);
         chk("busy clears", {26'h0, chs[i][3:0], 2'b01}, r);
         chk("mux_sel", chs[i], {28'h0, mux_sel});
         chk("acquire cycles", tads[acqc[i]] * (TAD_CYC << i), acq_n);
         v = RES_BITS'(chs[i] * 61 + 7);
         xfer(0, OFF_RESH, 0);
         chk("result high", i[0] ? {30'h0, v[9:8]} : {24'h0, v[9:2]}, r);
         xfer(0, OFF_RESL, 0);
         chk("result low", i[0] ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h0}, r);
         $display("test conversion %0d done", i);
      end
      xfer(1, OFF_CTRL, {26'h0, 4'h5, 2'b11});
      xfer(1, OFF_CTRL, 32'h0000_0002);
      xfer(0, OFF_CTRL, 0);
      chk("off", 32'h0000_0000, {r[31:1], conv_power});
      chk("abort sample_en", 32'h0000_0000, {31'h0, sample_en});
      $display("test power off done");
      close_out();
   end
endmodule
